// ---- fosc_pkg.sv ----
// Constants and types of the flash overlay space controller
package fosc_pkg;
   localparam int ADDR_W = 25;
   localparam int SECT_LSB = 17;
   localparam int SECT_W = 8;
   localparam int NSECT = 256;
   localparam int WORD_W = 16;
   localparam int ECC_ST_W = 5;
   localparam logic [16:0] SSR_WORDS = 17'h00200;
   localparam logic [ADDR_W-1:0] CFG_LOC = 25'h0000000;
   localparam logic [ADDR_W-1:0] PWD_WORDS = 25'h0000004;
   localparam logic [15:0] CFG_RST = 16'hffff;
   localparam logic [63:0] PWD_RST = 64'hffffffffffffffff;
   localparam logic LOCK_RST = 1'b1;
   localparam logic [15:0] UNDEF_WORD = 16'hffff;
   localparam logic [1:0] ECC_SEL_STATUS = 2'h0;
   localparam logic [1:0] ECC_SEL_TRAP_LO = 2'h1;
   localparam logic [1:0] ECC_SEL_TRAP_HI = 2'h2;
   localparam logic [1:0] ECC_SEL_COUNT = 2'h3;

   typedef enum logic [3:0] {
      OV_READ = 4'h0, OV_STATUS = 4'h1, OV_SSR = 4'h3, OV_CFG = 4'h2, OV_PWD = 4'h6,
      OV_PPB = 4'h7, OV_LOCK = 4'h5, OV_DYB = 4'h4, OV_ECC = 4'hc, OV_CRC = 4'hd
   } fosc_overlay_e;

   typedef enum logic [1:0] {EAC_STANDBY = 2'h0, EAC_ERS_SUSP = 2'h1} fosc_eac_e;

   typedef enum logic [4:0] {
      CMD_NOP = 5'h00, CMD_SR_READ = 5'h01, CMD_SSR_ENTRY = 5'h02, CMD_SSR_EXIT = 5'h03,
      CMD_CFG_ENTRY = 5'h04, CMD_PWD_ENTRY = 5'h05, CMD_PPB_ENTRY = 5'h06, CMD_LOCK_ENTRY = 5'h07,
      CMD_DYB_ENTRY = 5'h08, CMD_ECC_ENTRY = 5'h09, CMD_CRC_ENTRY = 5'h0a, CMD_SET_EXIT = 5'h0b,
      CMD_ASO_EXIT = 5'h0c, CMD_WORD_PROG = 5'h0d, CMD_BUF_PROG = 5'h0e, CMD_PPB_ERASE = 5'h0f,
      CMD_PWD_UNLOCK = 5'h10, CMD_RESET = 5'h11, CMD_ECC_SEL = 5'h12, CMD_CRC_LD_START = 5'h13,
      CMD_CRC_LD_END = 5'h14, CMD_CRC_SUSPEND = 5'h15, CMD_CRC_RESUME = 5'h16, CMD_CRC_RESULT = 5'h17
   } fosc_cmd_e;
endpackage

// ---- fosc_overlay_ctrl.sv ----
// Overlay space controller: command interpreter and read mux of the flash device
`timescale 1ns/10ps
module fosc_overlay_ctrl import fosc_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic [4:0] cmdCode,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic [WORD_W-1:0] cmdData,
   input wire logic rdValid,
   input wire logic rdFirst,
   input wire logic [ADDR_W-1:0] rdAddr,
   input wire logic [WORD_W-1:0] arrayData,
   input wire logic [WORD_W-1:0] statusIn,
   input wire logic [ECC_ST_W-1:0] eccStatusIn,
   input wire logic [WORD_W-1:0] eccTrapLo,
   input wire logic [WORD_W-1:0] eccTrapHi,
   input wire logic [WORD_W-1:0] eccCount,
   input wire logic [31:0] crcResult,
   input wire logic eaBusy,
   input wire logic eraseSuspended,
   input wire logic errorClear,
   output logic rdFromSsr,
   output logic [WORD_W-1:0] rdData,
   output logic rdUndef,
   output logic [3:0] overlayState,
   output logic [1:0] eacState,
   output logic timeoutClear,
   output logic progReq,
   output logic progToSsr,
   output logic [ADDR_W-1:0] progAddr,
   output logic [WORD_W-1:0] progData,
   output logic [NSECT-1:0] persistentProtectBit,
   output logic [NSECT-1:0] dynamicProtectBit,
   output logic persistentBitGlobalLock,
   output logic [15:0] protectionConfigWord,
   output logic [ADDR_W-1:0] crcStartAddr,
   output logic [ADDR_W-1:0] crcEndAddr,
   output logic crcRunning,
   output logic crcSuspended
);
   typedef struct packed {
      fosc_overlay_e ov;
      fosc_overlay_e savedOv;
      fosc_eac_e eac;
      logic [15:0] srSnap;
      logic srBurst;
      logic [SECT_W-1:0] ssrSector;
      logic [15:0] cfgWord;
      logic [63:0] pwd;
      logic [3:0] pwdMatch;
      logic lock;
      logic [NSECT-1:0] persistent_protect_bit;
      logic [NSECT-1:0] dynamic_protect_bit;
      logic [1:0] eccSel;
      logic [ADDR_W-1:0] crcStart;
      logic [ADDR_W-1:0] crcEnd;
      logic crcSusp;
      logic [WORD_W-1:0] rdData;
      logic rdUndef;
      logic toutClr;
      logic progReq;
      logic progSsr;
      logic [ADDR_W-1:0] progAddr;
      logic [WORD_W-1:0] progData;
   } fosc_state_s;

   fosc_state_s st_reg;
   fosc_state_s st_next;
   fosc_cmd_e cmd;
   logic [SECT_W-1:0] rdSect;
   logic [SECT_W-1:0] cmdSect;
   logic rdInSsrSect;
   logic isProg;
   logic isExit;

   assign cmd = fosc_cmd_e'(cmdCode);
   assign rdSect = rdAddr[ADDR_W-1:SECT_LSB];
   assign cmdSect = cmdAddr[ADDR_W-1:SECT_LSB];
   assign rdInSsrSect = (st_reg.ov == OV_SSR) && (rdSect == st_reg.ssrSector);
   assign isProg = cmdValid && (cmd == CMD_WORD_PROG);
   assign isExit = cmdValid && ((cmd == CMD_ASO_EXIT) || (cmd == CMD_SET_EXIT));

   always_comb begin
      st_next = st_reg;
      st_next.toutClr = 1'b0;
      st_next.progReq = 1'b0;
      st_next.progSsr = 1'b0;
      // Read path: one registered word per accepted read beat
      if (rdValid) begin
         st_next.rdUndef = 1'b0;
         st_next.rdData = arrayData;
         if (rdFirst) begin
            st_next.srBurst = 1'b0;
         end
         case (st_reg.ov)
            OV_STATUS: begin
               st_next.rdData = st_reg.srSnap;
               st_next.srBurst = 1'b1;
               st_next.ov = st_reg.savedOv;
            end
            OV_SSR: begin
               if (rdInSsrSect && (rdAddr[SECT_LSB-1:0] >= SSR_WORDS)) begin
                  st_next.rdUndef = 1'b1;
               end
            end
            OV_CFG: begin
               st_next.rdData = st_reg.cfgWord;
               st_next.rdUndef = (rdAddr != CFG_LOC);
            end
            OV_PWD: begin
               st_next.rdData = st_reg.pwd[rdAddr[1:0]*16 +: 16];
               st_next.rdUndef = (rdAddr >= PWD_WORDS);
            end
            OV_PPB: st_next.rdData = {15'h0000, st_reg.persistent_protect_bit[rdSect]};
            OV_LOCK: st_next.rdData = {15'h0000, st_reg.lock};
            OV_DYB: st_next.rdData = {15'h0000, st_reg.dynamic_protect_bit[rdSect]};
            OV_ECC: begin
               case (st_reg.eccSel)
                  ECC_SEL_STATUS: st_next.rdData = {11'h000, eccStatusIn};
                  ECC_SEL_TRAP_LO: st_next.rdData = eccTrapLo;
                  ECC_SEL_TRAP_HI: st_next.rdData = eccTrapHi;
                  default: st_next.rdData = eccCount;
               endcase
            end
            OV_CRC: begin
               if (!st_reg.crcSusp) begin
                  st_next.rdData = rdAddr[0] ? crcResult[31:16] : crcResult[15:0];
               end
            end
            default: ;
         endcase
         // Later beats of a status burst carry no status
         if (st_reg.srBurst && !rdFirst && st_reg.ov != OV_STATUS) begin
            st_next.rdUndef = 1'b1;
         end
         if (st_next.rdUndef) begin
            st_next.rdData = UNDEF_WORD;
         end
      end
      // Command path
      if (cmdValid) begin
         if (cmd == CMD_SR_READ) begin
            st_next.srSnap = statusIn;
            st_next.savedOv = st_reg.ov;
            st_next.ov = OV_STATUS;
         end else if (cmd == CMD_RESET) begin
            // A running program or erase keeps its overlay and controller state
            if (!eaBusy) begin
               st_next.ov = OV_READ;
               st_next.eac = EAC_STANDBY;
               st_next.toutClr = 1'b1;
               st_next.crcSusp = 1'b0;
               st_next.eccSel = ECC_SEL_STATUS;
            end
         end else begin
            case (st_reg.ov)
               OV_READ: begin
                  case (cmd)
                     CMD_SSR_ENTRY: begin
                        st_next.ov = OV_SSR;
                        st_next.ssrSector = cmdSect;
                     end
                     CMD_CFG_ENTRY: st_next.ov = OV_CFG;
                     CMD_PWD_ENTRY: begin
                        st_next.ov = OV_PWD;
                        st_next.pwdMatch = 4'h0;
                     end
                     CMD_PPB_ENTRY: st_next.ov = OV_PPB;
                     CMD_LOCK_ENTRY: st_next.ov = OV_LOCK;
                     CMD_DYB_ENTRY: st_next.ov = OV_DYB;
                     CMD_ECC_ENTRY: st_next.ov = OV_ECC;
                     CMD_CRC_ENTRY: st_next.ov = OV_CRC;
                     CMD_WORD_PROG, CMD_BUF_PROG: st_next.progReq = 1'b1;
                     default: ;
                  endcase
               end
               OV_SSR: begin
                  if (isExit || cmd == CMD_SSR_EXIT) begin
                     st_next.ov = OV_READ;
                  end else if (cmd == CMD_WORD_PROG || cmd == CMD_BUF_PROG) begin
                     st_next.progReq = 1'b1;
                     st_next.progSsr = (cmdSect == st_reg.ssrSector) && (cmdAddr[SECT_LSB-1:0] < SSR_WORDS);
                  end
               end
               OV_CFG, OV_PWD, OV_PPB, OV_LOCK, OV_DYB: begin
                  if (isExit) begin
                     st_next.ov = OV_READ;
                  end else if (isProg) begin
                     case (st_reg.ov)
                        OV_CFG: st_next.cfgWord = cmdData;
                        OV_PWD: st_next.pwd[cmdAddr[1:0]*16 +: 16] = cmdData;
                        OV_PPB: st_next.persistent_protect_bit[cmdSect] = 1'b1;
                        OV_LOCK: st_next.lock = 1'b0;
                        default: st_next.dynamic_protect_bit[cmdSect] = cmdData[0];
                     endcase
                  end else if (st_reg.ov == OV_PPB && cmd == CMD_PPB_ERASE) begin
                     st_next.persistent_protect_bit = '0;
                  end else if (st_reg.ov == OV_PWD && cmd == CMD_PWD_UNLOCK) begin
                     // Words arrive in any order; unlock needs the last word sent at each of the four addresses to match
                     st_next.pwdMatch[cmdAddr[1:0]] = (cmdData == st_reg.pwd[cmdAddr[1:0]*16 +: 16]);
                     if (&st_next.pwdMatch) begin
                        st_next.lock = 1'b0;
                        st_next.pwdMatch = 4'h0;
                     end
                  end
               end
               OV_ECC: begin
                  if (cmd == CMD_ASO_EXIT) begin
                     st_next.ov = OV_READ;
                     st_next.eccSel = ECC_SEL_STATUS;
                  end else if (cmd == CMD_ECC_SEL) begin
                     st_next.eccSel = cmdData[1:0];
                  end
               end
               OV_CRC: begin
                  case (cmd)
                     CMD_ASO_EXIT: begin
                        st_next.ov = OV_READ;
                        st_next.crcSusp = 1'b0;
                     end
                     CMD_CRC_RESUME: st_next.crcSusp = 1'b0;
                     default: begin
                        // While suspended only array reads, status read, reset, resume and exit are honoured
                        if (!st_reg.crcSusp) begin
                           case (cmd)
                              CMD_CRC_LD_START: st_next.crcStart = cmdAddr;
                              CMD_CRC_LD_END: st_next.crcEnd = cmdAddr;
                              CMD_CRC_SUSPEND: st_next.crcSusp = 1'b1;
                              default: ;
                           endcase
                        end
                     end
                  endcase
               end
               default: ;
            endcase
         end
         if (st_next.progReq) begin
            st_next.progAddr = cmdAddr;
            st_next.progData = cmdData;
         end
      end
      // Error clear keeps any overlay; otherwise pick erase-suspend or standby
      if (errorClear && st_next.ov == OV_READ) begin
         st_next.eac = eraseSuspended ? EAC_ERS_SUSP : EAC_STANDBY;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '{ov: OV_READ, savedOv: OV_READ, eac: EAC_STANDBY, cfgWord: CFG_RST, pwd: PWD_RST,
                     lock: LOCK_RST, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdFromSsr = rdInSsrSect;
   assign rdData = st_reg.rdData;
   assign rdUndef = st_reg.rdUndef;
   assign overlayState = st_reg.ov;
   assign eacState = st_reg.eac;
   assign timeoutClear = st_reg.toutClr;
   assign progReq = st_reg.progReq;
   assign progToSsr = st_reg.progSsr;
   assign progAddr = st_reg.progAddr;
   assign progData = st_reg.progData;
   assign persistentProtectBit = st_reg.persistent_protect_bit;
   assign dynamicProtectBit = st_reg.dynamic_protect_bit;
   assign persistentBitGlobalLock = st_reg.lock;
   assign protectionConfigWord = st_reg.cfgWord;
   assign crcStartAddr = st_reg.crcStart;
   assign crcEndAddr = st_reg.crcEnd;
   assign crcRunning = (st_reg.ov == OV_CRC) && !st_reg.crcSusp;
   assign crcSuspended = (st_reg.ov == OV_CRC) && st_reg.crcSusp;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_sr_entry: assert property (cmdValid && cmd == CMD_SR_READ |=> st_reg.ov == OV_STATUS
      && st_reg.srSnap == $past(statusIn)) else $error("status entry failed");
   a_sr_exit_restore: assert property (st_reg.ov == OV_STATUS && rdValid && !cmdValid
      |=> st_reg.ov == $past(st_reg.savedOv) && rdData == $past(st_reg.srSnap)) else $error("status exit wrong");
   a_sr_burst_undef: assert property ((st_reg.ov == OV_STATUS && rdValid) ##1 (rdValid && !rdFirst)
      |=> rdUndef) else $error("status burst beat not undefined");
   a_ssr_other_sector: assert property (st_reg.ov == OV_SSR && rdValid && !rdInSsrSect && !cmdValid
      && (rdFirst || !st_reg.srBurst)
      |=> st_reg.ov == OV_SSR && !rdUndef && rdData == $past(arrayData)) else $error("secure overlay read wrong");
   a_cfg_location: assert property (st_reg.ov == OV_CFG && rdValid && !st_reg.srBurst
      |=> rdUndef == ($past(rdAddr) != CFG_LOC)) else $error("config location map wrong");
   a_pwd_range: assert property (st_reg.ov == OV_PWD && rdValid && rdAddr >= PWD_WORDS
      |=> rdUndef) else $error("password range not undefined");
   a_lock_clear: assert property (st_reg.ov == OV_LOCK && isProg |=> !persistentBitGlobalLock)
      else $error("lock bit not cleared");
   a_reset_exit: assert property (cmdValid && cmd == CMD_RESET && !eaBusy
      |=> st_reg.ov == OV_READ && timeoutClear ##1 !timeoutClear) else $error("software reset failed");
   a_reset_ignored: assert property (cmdValid && cmd == CMD_RESET && eaBusy && st_reg.ov != OV_STATUS
      && !rdValid |=> $stable(st_reg.ov) && !timeoutClear) else $error("reset taken during operation");
   a_err_clear_susp: assert property (errorClear && !cmdValid && st_reg.ov == OV_READ && eraseSuspended
      |=> eacState == EAC_ERS_SUSP) else $error("error clear state wrong");
endmodule // fosc_overlay_ctrl

// ---- fosc_storage_model.sv ----
// Storage model answering array and secure-region reads
`timescale 1ns/10ps
module fosc_storage_model import fosc_pkg::*; (
   input wire logic [ADDR_W-1:0] rdAddr,
   input wire logic rdFromSsr,
   output logic [WORD_W-1:0] arrayData
);
   // Pattern depends on space and address, so a read from the wrong place shows up
   function automatic logic [WORD_W-1:0] arrWord(input logic [ADDR_W-1:0] a, input logic s);
      return s ? {4'h5, a[11:0]} : (a[15:0] ^ a[24:9] ^ 16'h3c3c);
   endfunction
   assign arrayData = arrWord(rdAddr, rdFromSsr);
endmodule // fosc_storage_model

// ---- fosc_overlay_ctrl_tb_top.sv ----
// Self-checking testbench of the flash overlay space controller
`timescale 1ns/10ps
module fosc_overlay_ctrl_tb_top import fosc_pkg::*;;
   logic mclk = 1'b0, rst = 1'b1, cmdValid = 1'b0, rdValid = 1'b0, rdFirst = 1'b0;
   logic eaBusy = 1'b0, eraseSuspended = 1'b0, errorClear = 1'b0, rdSeen = 1'b0;
   logic [4:0] cmdCode = 5'h00;
   logic [ADDR_W-1:0] cmdAddr = '0, rdAddr = '0, progAddr, crcStartAddr, crcEndAddr, a;
   logic [WORD_W-1:0] cmdData = '0, statusIn = '0, eccTrapLo = '0, eccTrapHi = '0, eccCount = '0;
   logic [WORD_W-1:0] arrayData, rdData, progData, protectionConfigWord, v;
   logic [WORD_W-1:0] pw[4];
   logic [ECC_ST_W-1:0] eccStatusIn = '0;
   logic [31:0] crcResult = '0;
   logic [3:0] overlayState;
   logic [1:0] eacState;
   logic [NSECT-1:0] persistentProtectBit, dynamicProtectBit;
   logic rdFromSsr, rdUndef, timeoutClear, progReq, progToSsr, persistentBitGlobalLock, crcRunning, crcSuspended;
   logic [33:0] expQ[$];
   logic [33:0] e;
   logic [4:0] ent[6] = '{CMD_SSR_ENTRY, CMD_CFG_ENTRY, CMD_PWD_ENTRY, CMD_PPB_ENTRY, CMD_LOCK_ENTRY, CMD_DYB_ENTRY};
   logic [3:0] ovs[6] = '{OV_SSR, OV_CFG, OV_PWD, OV_PPB, OV_LOCK, OV_DYB};
   localparam logic [16:0] ALL = 17'h1ffff;
   localparam logic [16:0] B0 = 17'h00001;
   localparam logic [16:0] UND = {1'b1, UNDEF_WORD};
   int n_mismatch = 0;
   int num_checks = 0;

   always #2.5 mclk = ~mclk;

   fosc_overlay_ctrl DUT (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .rdValid(rdValid), .rdFirst(rdFirst), .rdAddr(rdAddr), .arrayData(arrayData),
      .statusIn(statusIn), .eccStatusIn(eccStatusIn), .eccTrapLo(eccTrapLo), .eccTrapHi(eccTrapHi),
      .eccCount(eccCount), .crcResult(crcResult), .eaBusy(eaBusy), .eraseSuspended(eraseSuspended),
      .errorClear(errorClear), .rdFromSsr(rdFromSsr), .rdData(rdData), .rdUndef(rdUndef),
      .overlayState(overlayState), .eacState(eacState), .timeoutClear(timeoutClear), .progReq(progReq),
      .progToSsr(progToSsr), .progAddr(progAddr), .progData(progData),
      .persistentProtectBit(persistentProtectBit), .dynamicProtectBit(dynamicProtectBit),
      .persistentBitGlobalLock(persistentBitGlobalLock), .protectionConfigWord(protectionConfigWord),
      .crcStartAddr(crcStartAddr), .crcEndAddr(crcEndAddr), .crcRunning(crcRunning), .crcSuspended(crcSuspended));

   fosc_storage_model st (.rdAddr(rdAddr), .rdFromSsr(rdFromSsr), .arrayData(arrayData));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One idle cycle follows every command, so a status read never meets a stray command
   task automatic cmd(input logic [4:0] c, input logic [ADDR_W-1:0] ad, input logic [WORD_W-1:0] d);
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode = c;
      cmdAddr = ad;
      cmdData = d;
      @(negedge mclk);
      cmdValid = 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] ad, input logic f, input logic [16:0] m, input logic [16:0] x);
      @(negedge mclk);
      rdValid = 1'b1;
      rdFirst = f;
      rdAddr = ad;
      expQ.push_back({m, x & m});
      @(negedge mclk);
      rdValid = 1'b0;
   endtask

   task automatic clr();
      @(negedge mclk);
      errorClear = 1'b1;
      @(negedge mclk);
      errorClear = 1'b0;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge mclk) rdSeen <= rdValid && !rst;

   // An unexpected beat meets an unknown expectation and is counted
   always @(negedge mclk) begin
      if (rdSeen) begin
         e = (expQ.size() != 0) ? expQ.pop_front() : {ALL, 17'hx};
         chk({rdUndef, rdData} & e[33:17], e[16:0]);
      end
   end

   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end

   initial begin
      void'($urandom(80898));
      eccStatusIn = ECC_ST_W'($urandom);
      eccTrapLo = 16'($urandom);
      eccTrapHi = 16'($urandom);
      eccCount = 16'($urandom);
      crcResult = $urandom;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      chk({overlayState, eacState, persistentBitGlobalLock, protectionConfigWord}, {OV_READ, EAC_STANDBY, LOCK_RST, CFG_RST});
      for (int k = 0; k < 4; k++) begin
         a = ADDR_W'($urandom);
         rd(a, 1'b1, ALL, {1'b0, st.arrWord(a, 1'b0)});
      end
      v = 16'($urandom);
      statusIn = v;
      cmd(CMD_SR_READ, '0, '0);
      statusIn = ~v;
      chk(overlayState, OV_STATUS);
      rd(25'h0000040, 1'b1, ALL, {1'b0, v});
      rd(25'h0000041, 1'b0, ALL, UND);
      chk(overlayState, OV_READ);
      // Back-to-back burst: only the first beat carries the snapshot
      cmd(CMD_SR_READ, '0, '0);
      @(negedge mclk);
      rdValid = 1'b1;
      rdFirst = 1'b1;
      expQ.push_back({ALL, 1'b0, ~v});
      @(negedge mclk);
      rdFirst = 1'b0;
      rdAddr = 25'h0000042;
      expQ.push_back({ALL, UND});
      @(negedge mclk);
      rdValid = 1'b0;
      cmd(CMD_SSR_ENTRY, {8'h05, 17'h00000}, '0);
      rd({8'h05, 17'h00003}, 1'b1, ALL, {1'b0, st.arrWord({8'h05, 17'h00003}, 1'b1)});
      rd({8'h05, 17'h00300}, 1'b1, ALL, UND);
      rd({8'h06, 17'h00003}, 1'b1, ALL, {1'b0, st.arrWord({8'h06, 17'h00003}, 1'b0)});
      chk(overlayState, OV_SSR);
      statusIn = v;
      cmd(CMD_SR_READ, '0, '0);
      rd(25'h0000000, 1'b1, ALL, {1'b0, v});
      chk(overlayState, OV_SSR);
      cmd(CMD_WORD_PROG, {8'h05, 17'h00010}, ~v);
      chk({progReq, progToSsr, progData}, {2'b11, ~v});
      cmd(CMD_BUF_PROG, {8'h05, 17'h00020}, v);
      chk({progReq, progToSsr, progAddr}, {2'b11, 8'h05, 17'h00020});
      cmd(CMD_WORD_PROG, {8'h06, 17'h00010}, v);
      chk({progReq, progToSsr}, 2'b10);
      cmd(CMD_ASO_EXIT, '0, '0);
      for (int i = 0; i < 6; i++) begin
         for (int j = 0; j < 2; j++) begin
            cmd(ent[i], '0, '0);
            chk(overlayState, ovs[i]);
            cmd(j ? CMD_ASO_EXIT : (i ? CMD_SET_EXIT : CMD_SSR_EXIT), '0, '0);
            chk(overlayState, OV_READ);
         end
      end
      cmd(CMD_CFG_ENTRY, {8'h44, 17'h00000}, '0);
      cmd(CMD_WORD_PROG, '0, v);
      chk(protectionConfigWord, v);
      rd(25'h0000000, 1'b1, ALL, {1'b0, v});
      rd(25'h0000001, 1'b1, ALL, UND);
      cmd(CMD_SET_EXIT, '0, '0);
      cmd(CMD_PWD_ENTRY, '0, '0);
      for (int k = 0; k < 4; k++) begin
         pw[k] = 16'($urandom);
         cmd(CMD_WORD_PROG, ADDR_W'(k), pw[k]);
      end
      for (int k = 0; k < 5; k++) rd(ADDR_W'(k), 1'b1, ALL, (k < 4) ? {1'b0, pw[k]} : UND);
      for (int k = 0; k < 4; k++) cmd(CMD_PWD_UNLOCK, ADDR_W'(k), pw[k]);
      chk(persistentBitGlobalLock, 1'b0);
      @(negedge mclk);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      chk({overlayState, persistentBitGlobalLock}, {OV_READ, 1'b1});
      cmd(CMD_PPB_ENTRY, '0, '0);
      cmd(CMD_WORD_PROG, {8'h09, 17'h00000}, '0);
      chk(persistentProtectBit[9], 1'b1);
      rd({8'h09, 17'h00044}, 1'b1, B0, 17'h00001);
      rd({8'h0a, 17'h00044}, 1'b1, B0, 17'h00000);
      cmd(CMD_PPB_ERASE, '0, '0);
      chk(|persistentProtectBit, 1'b0);
      cmd(CMD_ASO_EXIT, '0, '0);
      cmd(CMD_LOCK_ENTRY, '0, '0);
      rd({8'h33, 17'h01234}, 1'b1, B0, 17'h00001);
      cmd(CMD_WORD_PROG, '0, '0);
      chk(persistentBitGlobalLock, 1'b0);
      rd({8'hc1, 17'h1ffff}, 1'b1, B0, 17'h00000);
      cmd(CMD_SET_EXIT, '0, '0);
      cmd(CMD_DYB_ENTRY, '0, '0);
      cmd(CMD_WORD_PROG, {8'hff, 17'h00000}, 16'h0001);
      chk(dynamicProtectBit[255], 1'b1);
      rd({8'hff, 17'h00777}, 1'b1, B0, 17'h00001);
      cmd(CMD_WORD_PROG, {8'hff, 17'h00000}, 16'h0000);
      chk(dynamicProtectBit[255], 1'b0);
      cmd(CMD_ASO_EXIT, '0, '0);
      cmd(CMD_ECC_ENTRY, '0, '0);
      rd(25'h0000123, 1'b1, 17'h1001f, {12'h000, eccStatusIn});
      cmd(CMD_ECC_SEL, '0, {14'h0000, ECC_SEL_TRAP_LO});
      rd(25'h0000000, 1'b1, ALL, {1'b0, eccTrapLo});
      cmd(CMD_ECC_SEL, '0, {14'h0000, ECC_SEL_TRAP_HI});
      rd(25'h0000000, 1'b1, ALL, {1'b0, eccTrapHi});
      cmd(CMD_ECC_SEL, '0, {14'h0000, ECC_SEL_COUNT});
      rd(25'h0000000, 1'b1, ALL, {1'b0, eccCount});
      cmd(CMD_ASO_EXIT, '0, '0);
      chk(overlayState, OV_READ);
      cmd(CMD_CRC_ENTRY, '0, '0);
      chk(overlayState, OV_CRC);
      a = ADDR_W'($urandom);
      cmd(CMD_CRC_LD_START, a, '0);
      cmd(CMD_CRC_LD_END, ~a, '0);
      chk({crcStartAddr, crcEndAddr}, {a, ~a});
      cmd(CMD_CRC_SUSPEND, '0, '0);
      chk({crcSuspended, crcRunning}, 2'b10);
      rd(a, 1'b1, ALL, {1'b0, st.arrWord(a, 1'b0)});
      cmd(CMD_CRC_LD_START, ~a, '0);
      chk(crcStartAddr, a);
      cmd(CMD_CRC_RESUME, '0, '0);
      chk({crcSuspended, crcRunning}, 2'b01);
      rd(a | 25'h0000001, 1'b1, ALL, {1'b0, crcResult[31:16]});
      rd(a & ~25'h0000001, 1'b1, ALL, {1'b0, crcResult[15:0]});
      cmd(CMD_CRC_RESULT, '0, '0);
      cmd(CMD_ASO_EXIT, '0, '0);
      chk(overlayState, OV_READ);
      cmd(CMD_CFG_ENTRY, '0, '0);
      cmd(CMD_RESET, '0, '0);
      chk({overlayState, eacState, timeoutClear}, {OV_READ, EAC_STANDBY, 1'b1});
      cmd(CMD_CFG_ENTRY, '0, '0);
      eaBusy = 1'b1;
      cmd(CMD_RESET, '0, '0);
      chk({overlayState, timeoutClear}, {OV_CFG, 1'b0});
      eaBusy = 1'b0;
      cmd(CMD_ASO_EXIT, '0, '0);
      eraseSuspended = 1'b1;
      clr();
      chk(eacState, EAC_ERS_SUSP);
      eraseSuspended = 1'b0;
      clr();
      chk(eacState, EAC_STANDBY);
      cmd(CMD_CFG_ENTRY, '0, '0);
      eraseSuspended = 1'b1;
      clr();
      chk({overlayState, eacState}, {OV_CFG, EAC_STANDBY});
      repeat (3) @(negedge mclk);
      chk(expQ.size(), 0);
      summarize();
   end
endmodule // fosc_overlay_ctrl_tb_top
